// ---- hdl/audio_tx_pkg.sv ----
// Constants for the multi-lane audio serial transmitter.
// Assumes a 32-bit AXI4-Lite register port and a single 100 MHz clock.
package audio_tx_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_DATA0   = 8'h00; // Lane 0 data port
  localparam logic [7:0] OFS_DATA1   = 8'h04;
  localparam logic [7:0] OFS_DATA2   = 8'h08;
  localparam logic [7:0] OFS_DATA3   = 8'h0C;
  localparam logic [7:0] OFS_CTRL    = 8'h10; // Enable, lanes, divider
  localparam logic [7:0] OFS_STATUS  = 8'h14; // Sticky events, clr on rd
  localparam logic [7:0] OFS_MASK    = 8'h18; // Interrupt enables
  localparam logic [7:0] OFS_LEVEL   = 8'h1C; // Live warning, full and empty flags

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int CTRL_TX_EN    = 0;
  localparam int CTRL_LANE_LSB = 4;
  localparam int CTRL_DIV_LSB  = 8;
  localparam int CTRL_FS_LSB   = 16;
  localparam int LANES         = 4;
  localparam int DIV_W         = 8;
  localparam int FS_W          = 8;

  // Defaults: master mode, left justified, 24-bit samples
  localparam logic [31:0] CTRL_RESET = 32'h0040_0300;
  localparam logic [7:0]  DIV_RESET  = 8'h03;
  localparam logic [7:0]  FS_RESET   = 8'h40;

  // ****************************************************************
  // Status bits
  // ****************************************************************
  localparam int ST_WARN  = 0; // An enabled FIFO ran empty at frame end
  localparam int ST_ERROR = 1; // Underrun: slot sent without data
  localparam int ST_W     = 2;

  // ****************************************************************
  // Frame layout
  // ****************************************************************
  localparam int SLOT_BITS     = 32; // Bit clocks per channel slot
  localparam int SAMPLE_BITS   = 24; // Valid sample bits per slot
  localparam int CH_PER_LANE   = 2;
  localparam int FIFO_DEPTH    = 32;
  localparam int DATA_W        = 32;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ---- hdl/multi_lane_audio_transmitter.sv ----
// Four-lane left-justified audio transmitter in clock-master mode.
// Assumes the codec is a slave following bit clock and frame sync, and
// software follows init, format, interrupts, enable, lane bring-up.
//
// Behaviour
// - Transmitter makes its own bit clock and frame sync.
// - Frame sync toggles at the end of every channel slot, twice per sample period.
// - Each channel slot carries a 24-bit serial word.
// - Upper 8 bits of every FIFO word are ignored.
// - One data port per lane, routed only to its FIFO.
// - Port write with space pushes word at FIFO tail.
// - Port write to a full FIFO is dropped unchanged.
// - Lane enables qualify the warning flag, evaluated at each frame end.
// - Lane enable field value 0xF enables all four lanes.
// - Warning sets when any enabled FIFO is empty.
// - Warning and error each have their own interrupt enable.
// - Reset config: master, left justified, divider, clock out on.
// - Transmitter masters clocks; codec is slave and detects rate.
// - Each lane owns a 32-entry, 32-bit FIFO.
// - Warning clears only when all enabled FIFOs hold data.
// - Each lane carries two channels per frame.
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
module multi_lane_audio_transmitter #(
  parameter int LANES = audio_tx_pkg::LANES,
  parameter int DEPTH = audio_tx_pkg::FIFO_DEPTH
) (
  // Clock, reset, enable
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  // AXI4-Lite write address
  input  wire logic [7:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  // Serial audio pins
  output logic              tx_bit_clock,
  output logic              tx_frame_sync,
  output logic [LANES-1:0]  tx_lane_data,
  output logic              audio_master_clock_out,
  // Interrupt
  output logic              irq
);

  localparam int AW = $clog2(DEPTH);
  localparam int SW = $clog2(audio_tx_pkg::SLOT_BITS);

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic                              tx_en_q;
  logic [LANES-1:0]                  tx_lane_enable_mask;
  logic [audio_tx_pkg::DIV_W-1:0]    div_q;
  logic [audio_tx_pkg::FS_W-1:0]     fs_div_q;
  logic [audio_tx_pkg::ST_W-1:0]     status_q;
  logic [audio_tx_pkg::ST_W-1:0]     mask_q;
  logic                              warn_q;

  // Write channel capture: address and data may arrive in either order
  logic        aw_held_q;
  logic        w_held_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_fire;
  logic        rd_fire;
  logic        status_rd;

  assign wr_fire   = aw_held_q && w_held_q && !s_axi_bvalid;
  assign rd_fire   = s_axi_arvalid && s_axi_arready;
  assign status_rd = rd_fire && (s_axi_araddr == audio_tx_pkg::OFS_STATUS);

  // ****************************************************************
  // FIFO storage, one per lane
  // ****************************************************************
  logic [audio_tx_pkg::DATA_W-1:0] mem_q [LANES][DEPTH];
  logic [AW-1:0]    wr_ptr_q [LANES];
  logic [AW-1:0]    rd_ptr_q [LANES];
  logic [AW:0]      count_q  [LANES];
  logic [LANES-1:0] push;
  logic [LANES-1:0] pop;
  logic [LANES-1:0] empty;
  logic [LANES-1:0] full;

  // ****************************************************************
  // Clock generation and frame timing
  // ****************************************************************
  logic [audio_tx_pkg::DIV_W-1:0] div_cnt_q;
  logic [SW-1:0]                  bit_cnt_q;
  logic                           slot_q;     // Channel within frame
  logic                           bclk_fall;
  logic                           frame_end;
  logic [audio_tx_pkg::FS_W-1:0]  mclk_cnt_q;

  // Bit clock half period from the divider; runs only while enabled
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_q    <= '0;
      tx_bit_clock <= 1'b0;
    end else if (clk_en) begin
      if (!tx_en_q) begin
        div_cnt_q    <= '0;
        tx_bit_clock <= 1'b0;
      end else if (div_cnt_q == div_q) begin
        div_cnt_q    <= '0;
        tx_bit_clock <= !tx_bit_clock;
      end else begin
        div_cnt_q <= div_cnt_q + 1'b1;
      end
    end
  end

  // Data changes on the falling bit clock edge so the codec samples
  // mid-bit on the rising edge
  assign bclk_fall = tx_en_q && tx_bit_clock && (div_cnt_q == div_q);
  assign frame_end = bclk_fall && slot_q &&
                     (bit_cnt_q == SW'(audio_tx_pkg::SLOT_BITS - 1));

  // Slot bit counter and channel select; frame sync is the channel
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q     <= '0;
      slot_q        <= 1'b0;
      tx_frame_sync <= 1'b0;
    end else if (clk_en) begin
      if (!tx_en_q) begin
        bit_cnt_q     <= '0;
        slot_q        <= 1'b0;
        tx_frame_sync <= 1'b0;
      end else if (bclk_fall) begin
        bit_cnt_q <= bit_cnt_q + 1'b1;
        if (bit_cnt_q == SW'(audio_tx_pkg::SLOT_BITS - 1)) begin
          slot_q        <= !slot_q;
          tx_frame_sync <= !slot_q;        // left justified
        end
      end
    end
  end

  // Master clock out, divided from the system clock, on from reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mclk_cnt_q             <= '0;
      audio_master_clock_out <= 1'b0;
    end else if (clk_en) begin
      if (mclk_cnt_q == fs_div_q) begin
        mclk_cnt_q             <= '0;
        audio_master_clock_out <= !audio_master_clock_out;
      end else begin
        mclk_cnt_q <= mclk_cnt_q + 1'b1;
      end
    end
  end

  // ****************************************************************
  // Per-lane FIFO and shifter
  // ****************************************************************
  logic [audio_tx_pkg::SAMPLE_BITS-1:0] shift_q [LANES];
  logic [LANES-1:0] underrun;

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      localparam logic [7:0] LANE_OFS = 8'(g * 4);
      // Each port writes only its own lane
      assign push[g] = wr_fire && (awaddr_q == LANE_OFS) &&
                       !full[g];
      // Load a new sample at the start of each slot of an enabled lane
      assign pop[g]  = bclk_fall && tx_lane_enable_mask[g] && !empty[g] &&
                       (bit_cnt_q == SW'(audio_tx_pkg::SLOT_BITS - 1));
      assign underrun[g] = bclk_fall && tx_lane_enable_mask[g] &&
                           empty[g] &&
                           (bit_cnt_q == SW'(audio_tx_pkg::SLOT_BITS - 1));
      assign empty[g] = (count_q[g] == '0);
      assign full[g]  = (count_q[g] == (AW+1)'(DEPTH));

      // Tail write; a push to a full FIFO never reaches the array
      always_ff @(posedge mclk) begin
        if (clk_en && push[g]) begin
          mem_q[g][wr_ptr_q[g]] <= wdata_q;
        end
      end

      // Pointers and fill count
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          wr_ptr_q[g] <= '0;
          rd_ptr_q[g] <= '0;
          count_q[g]  <= '0;
        end else if (clk_en) begin
          if (push[g]) wr_ptr_q[g] <= wr_ptr_q[g] + 1'b1;
          if (pop[g])  rd_ptr_q[g] <= rd_ptr_q[g] + 1'b1;
          if (push[g] && !pop[g]) count_q[g] <= count_q[g] + 1'b1;
          else if (pop[g] && !push[g]) count_q[g] <= count_q[g] - 1'b1;
        end
      end

      // MSB first shifter; only the low sample bits are sent
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          shift_q[g]      <= '0;
          tx_lane_data[g] <= 1'b0;
        end else if (clk_en) begin
          if (!tx_en_q || !tx_lane_enable_mask[g]) begin
            shift_q[g]      <= '0;
            tx_lane_data[g] <= 1'b0;
          end else if (pop[g]) begin
            shift_q[g] <= {mem_q[g][rd_ptr_q[g]]
                           [audio_tx_pkg::SAMPLE_BITS-2:0], 1'b0};
            tx_lane_data[g] <=
              mem_q[g][rd_ptr_q[g]][audio_tx_pkg::SAMPLE_BITS-1];
          end else if (underrun[g]) begin
            shift_q[g]      <= '0;
            tx_lane_data[g] <= 1'b0;
          end else if (bclk_fall) begin
            // Past 24 bits the slot pads with zeros
            tx_lane_data[g] <= shift_q[g][audio_tx_pkg::SAMPLE_BITS-1];
            shift_q[g]      <= {shift_q[g][audio_tx_pkg::SAMPLE_BITS-2:0],
                                1'b0};
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Flags and interrupt
  // ****************************************************************
  // Warning level re-evaluated once per frame over enabled lanes only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      warn_q <= 1'b0;
    end else if (clk_en && frame_end) begin
      warn_q <= |(empty & tx_lane_enable_mask);
    end
  end

  // Sticky events; a new event beats a read clear in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= '0;
    end else if (clk_en) begin
      status_q <= (status_rd ? '0 : status_q) |
                  {(|underrun),
                   frame_end && (|(empty & tx_lane_enable_mask))};
    end
  end

  // Each event gated by its own enable
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(status_q & mask_q);
    end
  end

  // ****************************************************************
  // AXI4-Lite write path
  // ****************************************************************
  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready  = !w_held_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end else if (clk_en) begin
      if (s_axi_awvalid && !aw_held_q) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_held_q) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Register writes and response; full-FIFO drops still answer OKAY
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_en_q             <= audio_tx_pkg::CTRL_RESET[audio_tx_pkg::CTRL_TX_EN];
      tx_lane_enable_mask <= '0;
      div_q               <= audio_tx_pkg::DIV_RESET;
      fs_div_q            <= audio_tx_pkg::FS_RESET;
      mask_q              <= '0;
      s_axi_bvalid        <= 1'b0;
      s_axi_bresp         <= audio_tx_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= audio_tx_pkg::RESP_OKAY;
        if (awaddr_q == audio_tx_pkg::OFS_CTRL) begin
          if (wstrb_q[0]) begin
            tx_en_q             <= wdata_q[audio_tx_pkg::CTRL_TX_EN];
            tx_lane_enable_mask <= wdata_q[audio_tx_pkg::CTRL_LANE_LSB +:
                                           LANES];
          end
          if (wstrb_q[1])
            div_q <= wdata_q[audio_tx_pkg::CTRL_DIV_LSB +:
                             audio_tx_pkg::DIV_W];
          if (wstrb_q[2])
            fs_div_q <= wdata_q[audio_tx_pkg::CTRL_FS_LSB +:
                                audio_tx_pkg::FS_W];
        end else if (awaddr_q == audio_tx_pkg::OFS_MASK) begin
          if (wstrb_q[0]) mask_q <= wdata_q[audio_tx_pkg::ST_W-1:0];
        end else if (awaddr_q <= audio_tx_pkg::OFS_DATA3 &&
                     awaddr_q[1:0] == 2'b00) begin
          s_axi_bresp <= audio_tx_pkg::RESP_OKAY;
        end else if (awaddr_q != audio_tx_pkg::OFS_STATUS &&
                     awaddr_q != audio_tx_pkg::OFS_LEVEL) begin
          s_axi_bresp <= audio_tx_pkg::RESP_SLVERR;
        end
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read path
  // ****************************************************************
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= audio_tx_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= '0;
        s_axi_rresp  <= audio_tx_pkg::RESP_OKAY;
        if (s_axi_araddr == audio_tx_pkg::OFS_CTRL) begin
          s_axi_rdata[audio_tx_pkg::CTRL_TX_EN] <= tx_en_q;
          s_axi_rdata[audio_tx_pkg::CTRL_LANE_LSB +: LANES] <=
            tx_lane_enable_mask;
          s_axi_rdata[audio_tx_pkg::CTRL_DIV_LSB +: audio_tx_pkg::DIV_W] <=
            div_q;
          s_axi_rdata[audio_tx_pkg::CTRL_FS_LSB +: audio_tx_pkg::FS_W] <=
            fs_div_q;
        end else if (s_axi_araddr == audio_tx_pkg::OFS_STATUS) begin
          s_axi_rdata[audio_tx_pkg::ST_W-1:0] <= status_q;
        end else if (s_axi_araddr == audio_tx_pkg::OFS_MASK) begin
          s_axi_rdata[audio_tx_pkg::ST_W-1:0] <= mask_q;
        end else if (s_axi_araddr == audio_tx_pkg::OFS_LEVEL) begin
          // Live warning in bit 0, full flags 4..7, empty flags 8..11
          s_axi_rdata[0]          <= warn_q;
          s_axi_rdata[4 +: LANES] <= full;
          s_axi_rdata[8 +: LANES] <= empty;
        end else if (s_axi_araddr > audio_tx_pkg::OFS_DATA3 ||
                     s_axi_araddr[1:0] != 2'b00) begin
          s_axi_rresp <= audio_tx_pkg::RESP_SLVERR;
        end
      end
    end
  end

endmodule

// ---- dv/audio_tx_assertions.sv ----
// Port-level checks for the four-lane audio transmitter.
// Assumes a single clock and the reset bit clock divider of three.
`timescale 1ns/1ns
module audio_tx_checker (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        clk_en,
  // Register bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Serial pins and interrupt
  input wire logic        tx_bit_clock,
  input wire logic        tx_frame_sync,
  input wire logic        irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ****************************************************************
  // Bus handshakes
  // ****************************************************************
  ready_after_rst_a:
    assert property ($rose(rst_n) |-> s_axi_awready && s_axi_wready
      && s_axi_arready) else $error("slave not ready after reset");
  bvalid_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write response dropped");
  bvalid_drop_a:
    assert property (s_axi_bvalid && s_axi_bready && clk_en |=>
      !s_axi_bvalid) else $error("write response repeated");
  bresp_delay_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready && clk_en |-> ##2 s_axi_bvalid)
      else $error("write response late");
  aw_block_a:
    assert property (s_axi_awvalid && s_axi_awready && clk_en |=>
      !s_axi_awready) else $error("second address taken");
  rvalid_next_a:
    assert property (s_axi_arvalid && s_axi_arready && clk_en |=>
      s_axi_rvalid) else $error("read data late");
  rvalid_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read data dropped");
  arready_busy_a:
    assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");

  // ****************************************************************
  // Serial link timing
  // ****************************************************************
  bclk_low_a:
    assert property ($fell(tx_bit_clock) |-> (!tx_bit_clock)[*4])
      else $error("bit clock low phase short");
  fs_edge_a:
    assert property ($changed(tx_frame_sync) |-> !tx_bit_clock)
      else $error("frame sync moved with bit clock high");

  // Main scenarios reached
  cover property ($rose(irq));
  cover property ($changed(tx_frame_sync));
  cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind multi_lane_audio_transmitter audio_tx_checker u_chk (
  .mclk, .rst_n, .clk_en, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .tx_bit_clock, .tx_frame_sync, .irq
);

// ---- dv/codec_model.sv ----
// Slave codec: receives four left-justified lanes, keeps the last word.
// Assumes the transmitter drives bit clock and frame sync.
`timescale 1ns/1ns
module codec_model (
  // Link pins from the transmitter
  input wire logic        rst_n,
  input wire logic        bclk,
  input wire logic        fs,
  input wire logic [3:0]  din,
  // Last word per lane and channel
  output logic [23:0]     word_q [4][2],
  output int              slots_q
);
  logic        fs_q;
  int          cnt_q;
  logic [23:0] sh_q [4];

  // Sample on bit clock rise; any frame sync edge starts a slot
  always @(posedge bclk or negedge rst_n) begin
    if (!rst_n) begin
      fs_q <= 1'b0;
      cnt_q <= 0;
      slots_q <= 0;
    end else begin
      fs_q <= fs;
      cnt_q <= (fs != fs_q) ? 1 : cnt_q + 1;
      for (int l = 0; l < 4; l++) begin
        sh_q[l] <= {(fs != fs_q) ? 23'h0 : sh_q[l][22:0], din[l]};
        if (cnt_q == 23 && fs == fs_q)
          word_q[l][fs] <= {sh_q[l][22:0], din[l]};
      end
      // Only the first 24 bits count; the slot tail is padding
      if (cnt_q == 23 && fs == fs_q)
        slots_q <= slots_q + 1;
    end
  end
endmodule

// ---- dv/test_multi_lane_audio_transmitter.sv ----
// Bench for the four-lane audio transmitter over its register bus.
// Assumes reset divider values and the bound checker.
`timescale 1ns/1ns
module test_multi_lane_audio_transmitter;
  logic        mclk, rst_n, irq, e;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, tx_bit_clock, tx_frame_sync;
  logic        audio_master_clock_out;
  logic [3:0]  tx_lane_data, acc;
  logic [23:0] word [4][2];
  int          slots, failures, checked, k, l;

  multi_lane_audio_transmitter i_dut (
    .mclk, .rst_n, .clk_en(1'b1), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_bit_clock,
    .tx_frame_sync, .tx_lane_data, .audio_master_clock_out, .irq);
  codec_model i_codec (.rst_n, .bclk(tx_bit_clock), .fs(tx_frame_sync),
    .din(tx_lane_data), .word_q(word), .slots_q(slots));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Sample word: junk upper byte so dropping it is visible
  function automatic logic [31:0] val(int ln, int i);
    return {8'hFF, 4'(ln + 8), 4'h3, 8'h5A, 8'(i)};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, g, x);
    end
  endtask

  task automatic conclude;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic tmo;
    failures++;
    $display("[FAIL] %0t wait ran out", $time);
    conclude;
  endtask

  // Bus cycles: ready is judged at the falling edge before the sample
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] x);
    int n;
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(negedge mclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge mclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 100) tmo;
    chk({30'h0, r}, {30'h0, x});
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] x,
                    output logic [31:0] v);
    int n;
    logic ta, tr;
    logic [1:0] r;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(negedge mclk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      v = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge mclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 100) tmo;
    chk({30'h0, r}, {30'h0, x});
  endtask

  // Bounded waits on the codec slot count and on clock-out toggles
  task automatic wait_slots(input int n);
    for (int i = 0; i < 40000; i++) begin
      @(negedge mclk);
      if (slots >= n) return;
    end
    tmo;
  endtask

  task automatic half(output int n);
    e = audio_master_clock_out;
    for (n = 0; n < 300; n++) begin
      @(negedge mclk);
      if (audio_master_clock_out !== e) break;
    end
    if (n == 300) tmo;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready, rst_n} = 3'b000;
    {s_axi_awaddr, s_axi_araddr} = 16'h0000;
    s_axi_wdata = 32'h0000_0000;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    rd(audio_tx_pkg::OFS_CTRL, 2'b00, d);
    chk(d, audio_tx_pkg::CTRL_RESET);
    rd(audio_tx_pkg::OFS_STATUS, 2'b00, d);
    chk(d, 32'h0000_0000);
    half(k);
    half(k);
    chk(32'(k + 1), 32'(audio_tx_pkg::FS_RESET) + 32'h1);
    rd(8'h20, audio_tx_pkg::RESP_SLVERR, d);
    $display("test reset done");
    // Lane 0 filled past its depth, two words on the others
    for (k = 0; k <= 32; k++)
      wr(audio_tx_pkg::OFS_DATA0, val(0, k), 2'b00);
    for (l = 1; l < 4; l++)
      for (k = 0; k < 2; k++)
        wr(8'(4 * l), val(l, k), 2'b00);
    rd(audio_tx_pkg::OFS_LEVEL, 2'b00, d);
    chk(d & 32'h0000_0FF0, 32'h0000_0010);
    // Interrupts, then transmitter, then lanes; first slot stays silent
    wr(audio_tx_pkg::OFS_MASK, 32'h0000_0003, 2'b00);
    wr(audio_tx_pkg::OFS_CTRL, audio_tx_pkg::CTRL_RESET | 32'h1,
      2'b00);
    wr(audio_tx_pkg::OFS_CTRL, audio_tx_pkg::CTRL_RESET | 32'hF1,
      2'b00);
    wait_slots(3);
    for (l = 0; l < 4; l++)
      for (k = 0; k < 2; k++)
        chk({8'h0, word[l][1 - k]}, val(l, k) & 32'hFF_FFFF);
    wait_slots(33);
    chk({8'h0, word[0][0]}, val(0, 31) & 32'hFF_FFFF);
    wait_slots(34);
    chk({8'h0, word[0][1]}, 32'h0000_0000);
    chk({31'h0, irq}, 32'h1);
    rd(audio_tx_pkg::OFS_STATUS, 2'b00, d);
    chk(d, 32'h0000_0003);
    wr(audio_tx_pkg::OFS_CTRL, audio_tx_pkg::CTRL_RESET, 2'b00);
    rd(audio_tx_pkg::OFS_STATUS, 2'b00, d);
    rd(audio_tx_pkg::OFS_STATUS, 2'b00, d);
    chk(d, 32'h0000_0000);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    $display("test stream done");
    // Only lane 0 enabled, four words queued, interrupts masked
    for (k = 0; k < 4; k++)
      wr(audio_tx_pkg::OFS_DATA0, val(0, k), 2'b00);
    wr(audio_tx_pkg::OFS_MASK, 32'h0000_0000, 2'b00);
    wr(audio_tx_pkg::OFS_CTRL, audio_tx_pkg::CTRL_RESET | 32'h1, 2'b00);
    wr(audio_tx_pkg::OFS_CTRL, audio_tx_pkg::CTRL_RESET | 32'h11,
      2'b00);
    rd(audio_tx_pkg::OFS_STATUS, 2'b00, d);
    acc = 4'h0;
    for (k = 0; k < 600; k++) begin
      @(negedge mclk);
      acc = acc | tx_lane_data;
    end
    chk({28'h0, acc & 4'hE}, 32'h0000_0000);
    rd(audio_tx_pkg::OFS_STATUS, 2'b00, d);
    chk(d, 32'h0000_0000);
    repeat (1100) @(posedge mclk);
    rd(audio_tx_pkg::OFS_STATUS, 2'b00, d);
    chk(d & 32'h1, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0);
    $display("test lane mask done");
    conclude;
  end
endmodule
